// [core/rco_defs.vh]
// Purpose: constants for the reference clock output block
// Assumes: 100 MHz system clock, 8-bit register port
// Notes: offsets are register indices on the plain port
`ifndef RCO_DEFS_VH
`define RCO_DEFS_VH

// register offsets
`define RCO_ADDR_CLOCK_GEN 4'h0
`define RCO_ADDR_REF_FIRST 4'h1
`define RCO_ADDR_REF_SECOND 4'h2
`define RCO_ADDR_DIV_FIRST 4'h3
`define RCO_ADDR_DIV_SECOND 4'h4
`define RCO_ADDR_STATUS 4'h5

// clock_gen_config fields
`define RCO_CG_T1_SEL 0
`define RCO_CG_T1_EN 1
`define RCO_CG_E1_SEL 2
`define RCO_CG_E1_EN 3

// reference config fields
`define RCO_REF_SRC_HI 4
`define RCO_REF_SRC_LO 0
`define RCO_REF_RATE_SEL 5
`define RCO_REF_EN 6
`define RCO_DIV_HI 2

// status fields
`define RCO_ST_LOST 4

// reset values
`define RCO_CLOCK_GEN_RST 8'h00
`define RCO_REF_CFG_RST 8'h00
`define RCO_DIV_RST 3'h0

// source codes
`define RCO_SRC_LAST_CHAN 5'h10
`define RCO_SRC_EXTERNAL 5'h11

// rates in kHz, doubled where used as toggle rates
`define RCO_T1_KHZ 12'h608
`define RCO_E1_KHZ 12'h800
`define RCO_TOGGLE_8K 18'h00010
`define RCO_TOGGLE_T1 18'h00C10
`define RCO_TOGGLE_E1 18'h01000
// system clock in kHz: one step per cycle, so no doubling here
`define RCO_FREE_MOD 18'h186A0

// timing
`define RCO_CLK_PERIOD_NS 10
`define RCO_LOSS_WINDOW_NS 10000
`define RCO_LOSS_WINDOW_CYC ((`RCO_LOSS_WINDOW_NS + `RCO_CLK_PERIOD_NS - 1) / `RCO_CLK_PERIOD_NS)
`define RCO_LOSS_MIN_PCT 30

`endif

// [core/rco_loss_mon.v]
// Purpose: master clock loss detector with recovery reset pulse
// Assumes: master clock sampled synchronously
// Notes: duty judged over fixed windows
`timescale 1ns/10ps
module rco_loss_mon #(
   parameter CW = 16,
   parameter WINDOW = 1000,
   parameter MIN_PCT = 30
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // monitored clock
   input wire mclk_in,
   // status
   output reg lost_out,
   output reg reset_pulse_out
);
   localparam [CW-1:0] WIN_LAST = WINDOW - 1;
   localparam [CW-1:0] THR = (WINDOW * MIN_PCT + 99) / 100;
   localparam [CW-1:0] THR_HI = WINDOW - ((WINDOW * MIN_PCT + 99) / 100);
   reg [CW-1:0] win_reg;
   reg [CW-1:0] high_reg;
   wire [CW-1:0] high_next = high_reg + {{(CW-1){1'b0}}, mclk_in};
   // duty under the floor, either polarity
   wire bad = (high_next < THR) || (high_next > THR_HI);

   always @(posedge clk) begin
      if (!rst_n) begin
         win_reg <= {CW{1'b0}};
         high_reg <= {CW{1'b0}};
         lost_out <= 1'b0;
         reset_pulse_out <= 1'b0;
      end else begin
         reset_pulse_out <= 1'b0;
         if (win_reg == WIN_LAST) begin
            win_reg <= {CW{1'b0}};
            high_reg <= {CW{1'b0}};
            if (bad) begin
               lost_out <= 1'b1;
            end else if (lost_out) begin
               lost_out <= 1'b0;
               reset_pulse_out <= 1'b1;
            end
         end else begin
            win_reg <= win_reg + {{(CW-1){1'b0}}, 1'b1};
            high_reg <= high_next;
         end
      end
   end
endmodule // rco_loss_mon

// [core/rco_rate_gen.v]
// Purpose: fractional rate generator, toggles output at inc/mod of steps
// Assumes: inc_in not above mod_in
// Notes: output is a flop, frequency locked to the step source
`timescale 1ns/10ps
module rco_rate_gen #(
   parameter W = 18
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // rate
   input wire step_in,
   input wire [W-1:0] inc_in,
   input wire [W-1:0] mod_in,
   // clock
   output reg clk_out
);
   reg [W-1:0] acc_reg;
   wire [W:0] sum = {1'b0, acc_reg} + {1'b0, inc_in};

   always @(posedge clk) begin
      if (!rst_n) begin
         acc_reg <= {W{1'b0}};
         clk_out <= 1'b0;
      end else if (acc_reg >= mod_in) begin
         // rate changed under us
         acc_reg <= {W{1'b0}};
      end else if (step_in) begin
         if (sum >= {1'b0, mod_in}) begin
            acc_reg <= sum[W-1:0] - mod_in;
            clk_out <= ~clk_out;
         end else begin
            acc_reg <= sum[W-1:0];
         end
      end
   end
endmodule // rco_rate_gen

// [core/rco_ref_clock_out.v]
// Purpose: rate clock outputs and two selectable reference clock outputs
// Assumes: all clock inputs sampled as synchronous to CLK_IN
// Notes: oe_n outputs low while the pin is driven
// Notes: rate outputs step on master edges only, so they follow the master
// Notes: free-run references step on the system clock instead
// Notes: clock loss recovery resets everything but the loss detector
`include "rco_defs.vh"
`timescale 1ns/10ps
module rco_ref_clock_out #(
   parameter CHANNELS = 17,
   parameter LOSS_WINDOW = `RCO_LOSS_WINDOW_CYC,
   parameter LOSS_MIN_PCT = `RCO_LOSS_MIN_PCT
) (
   // clock and reset
   input wire CLK_IN,
   input wire RST_N_IN,
   // register port
   input wire [3:0] ADDR_IN,
   input wire [7:0] WR_DATA_IN,
   input wire WR_EN_IN,
   input wire RD_EN_IN,
   output wire [7:0] RD_DATA_OUT,
   // master clock and straps
   input wire MASTER_CLOCK_IN,
   input wire [3:0] MASTER_FREQ_STRAPS_IN,
   // clock sources
   input wire [CHANNELS-1:0] RECOVERED_CLOCK_IN,
   input wire EXTERNAL_CLOCK_IN_FIRST_IN,
   input wire EXTERNAL_CLOCK_IN_SECOND_IN,
   // rate clock pins
   output wire T1_RATE_CLOCK_OUT,
   output wire T1_RATE_CLOCK_OE_N_OUT,
   output wire E1_RATE_CLOCK_OUT,
   output wire E1_RATE_CLOCK_OE_N_OUT,
   // reference clock pins
   output wire REFERENCE_OUT_FIRST_OUT,
   output wire REFERENCE_FIRST_OE_N_OUT,
   output wire REFERENCE_OUT_SECOND_OUT,
   output wire REFERENCE_SECOND_OE_N_OUT,
   // status
   output wire CLOCK_LOST_OUT
);
   wire lost;
   wire auto_reset;
   // device reset also from clock loss recovery
   wire rst_n = RST_N_IN & ~auto_reset;

   reg [7:0] clock_gen_config_reg;
   reg [15:0] ref_cfg_reg;
   reg [5:0] ref_div_reg;
   reg [7:0] rd_data_reg;
   reg [3:0] master_freq_straps_reg;
   reg strap_taken_reg;
   reg mclk_d_reg;
   reg mclk_armed_reg;
   reg [7:0] rd_data_next;

   // loss detector is held only by the pin reset
   rco_loss_mon #(
      .CW(16),
      .WINDOW(LOSS_WINDOW),
      .MIN_PCT(LOSS_MIN_PCT)
   ) u_loss (
      .clk(CLK_IN),
      .rst_n(RST_N_IN),
      .mclk_in(MASTER_CLOCK_IN),
      .lost_out(lost),
      .reset_pulse_out(auto_reset)
   );

   // strap capture after reset release
   always @(posedge CLK_IN) begin
      if (!rst_n) begin
         master_freq_straps_reg <= 4'h0;
         strap_taken_reg <= 1'b0;
      end else if (!strap_taken_reg) begin
         master_freq_straps_reg <= MASTER_FREQ_STRAPS_IN;
         strap_taken_reg <= 1'b1;
      end
   end

   // one decode per register, shared by writes and reads
   wire sel_clock_gen = (ADDR_IN == `RCO_ADDR_CLOCK_GEN);
   wire sel_ref_first = (ADDR_IN == `RCO_ADDR_REF_FIRST);
   wire sel_ref_second = (ADDR_IN == `RCO_ADDR_REF_SECOND);
   wire sel_div_first = (ADDR_IN == `RCO_ADDR_DIV_FIRST);
   wire sel_div_second = (ADDR_IN == `RCO_ADDR_DIV_SECOND);
   wire sel_status = (ADDR_IN == `RCO_ADDR_STATUS);
   wire [7:0] status_word = {3'h0, lost, master_freq_straps_reg};

   // register writes, reserved bits kept at zero
   always @(posedge CLK_IN) begin
      if (!rst_n) begin
         clock_gen_config_reg <= `RCO_CLOCK_GEN_RST;
         ref_cfg_reg <= {`RCO_REF_CFG_RST, `RCO_REF_CFG_RST};
         ref_div_reg <= {`RCO_DIV_RST, `RCO_DIV_RST};
      end else if (WR_EN_IN) begin
         if (sel_clock_gen) begin
            clock_gen_config_reg <= {4'h0, WR_DATA_IN[3:0]};
         end else if (sel_ref_first) begin
            ref_cfg_reg[7:0] <= {1'b0, WR_DATA_IN[6:0]};
         end else if (sel_ref_second) begin
            ref_cfg_reg[15:8] <= {1'b0, WR_DATA_IN[6:0]};
         end else if (sel_div_first) begin
            ref_div_reg[2:0] <= WR_DATA_IN[2:0];
         end else if (sel_div_second) begin
            ref_div_reg[5:3] <= WR_DATA_IN[2:0];
         end
      end
   end

   // read mux, idle and unmapped cycles give zero
   always @* begin
      rd_data_next = 8'h00;
      if (!RD_EN_IN) begin
         rd_data_next = 8'h00;
      end else if (sel_clock_gen) begin
         rd_data_next = clock_gen_config_reg;
      end else if (sel_ref_first) begin
         rd_data_next = ref_cfg_reg[7:0];
      end else if (sel_ref_second) begin
         rd_data_next = ref_cfg_reg[15:8];
      end else if (sel_div_first) begin
         rd_data_next = {5'h00, ref_div_reg[2:0]};
      end else if (sel_div_second) begin
         rd_data_next = {5'h00, ref_div_reg[5:3]};
      end else if (sel_status) begin
         rd_data_next = status_word;
      end else begin
         rd_data_next = 8'h00;
      end
   end

   // read data stands one cycle after the strobe, then zero
   always @(posedge CLK_IN) begin
      if (!rst_n) begin
         rd_data_reg <= 8'h00;
      end else begin
         rd_data_reg <= rd_data_next;
      end
   end
   assign RD_DATA_OUT = rd_data_reg;

   // master frequency from straps, in kHz
   wire [11:0] mclk_base = master_freq_straps_reg[3] ? `RCO_E1_KHZ : `RCO_T1_KHZ;
   wire [3:0] mclk_mult = {1'b0, master_freq_straps_reg[2:0]} + 4'h1;
   wire [15:0] mclk_khz = mclk_base * mclk_mult;
   // both master edges step the generators, so modulus is twice the rate
   wire [17:0] mclk_mod = {1'b0, mclk_khz, 1'b0};

   // detector armed one cycle after reset, so a high master
   // level at release is not taken for an edge
   always @(posedge CLK_IN) begin
      if (!rst_n) begin
         mclk_d_reg <= 1'b0;
         mclk_armed_reg <= 1'b0;
      end else begin
         mclk_d_reg <= MASTER_CLOCK_IN;
         mclk_armed_reg <= 1'b1;
      end
   end
   wire mclk_edge = mclk_armed_reg & (MASTER_CLOCK_IN ^ mclk_d_reg);

   // rate clocks stepped only by master edges
   wire [17:0] t1_inc = clock_gen_config_reg[`RCO_CG_T1_SEL] ?
                        `RCO_TOGGLE_T1 : `RCO_TOGGLE_8K;
   wire [17:0] e1_inc = clock_gen_config_reg[`RCO_CG_E1_SEL] ?
                        `RCO_TOGGLE_E1 : `RCO_TOGGLE_8K;

   rco_rate_gen #(
      .W(18)
   ) u_t1 (
      .clk(CLK_IN),
      .rst_n(rst_n),
      .step_in(mclk_edge),
      .inc_in(t1_inc),
      .mod_in(mclk_mod),
      .clk_out(T1_RATE_CLOCK_OUT)
   );

   rco_rate_gen #(
      .W(18)
   ) u_e1 (
      .clk(CLK_IN),
      .rst_n(rst_n),
      .step_in(mclk_edge),
      .inc_in(e1_inc),
      .mod_in(mclk_mod),
      .clk_out(E1_RATE_CLOCK_OUT)
   );

   // pins driven only while their enable bit is set
   wire t1_enable = clock_gen_config_reg[`RCO_CG_T1_EN];
   wire e1_enable = clock_gen_config_reg[`RCO_CG_E1_EN];
   assign T1_RATE_CLOCK_OE_N_OUT = ~t1_enable;
   assign E1_RATE_CLOCK_OE_N_OUT = ~e1_enable;

   // reference outputs
   wire [1:0] ext_clk = {EXTERNAL_CLOCK_IN_SECOND_IN, EXTERNAL_CLOCK_IN_FIRST_IN};
   wire [1:0] ref_out;
   wire [1:0] ref_oe_n;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_ref
         wire [7:0] cfg = ref_cfg_reg[g*8 +: 8];
         wire [2:0] div = ref_div_reg[g*3 +: 3];
         wire [4:0] src_sel = cfg[`RCO_REF_SRC_HI:`RCO_REF_SRC_LO];
         wire free_clk;
         // rate bit picks the free-run rate as well
         wire [17:0] free_inc = cfg[`RCO_REF_RATE_SEL] ? `RCO_TOGGLE_E1 : `RCO_TOGGLE_T1;
         reg src;
         reg src_d_reg;
         reg [7:0] cnt_reg;
         reg out_reg;

         // free-running clock at the rate named by the rate bit
         rco_rate_gen #(
            .W(18)
         ) u_free (
            .clk(CLK_IN),
            .rst_n(rst_n),
            .step_in(1'b1),
            .inc_in(free_inc),
            .mod_in(`RCO_FREE_MOD),
            .clk_out(free_clk)
         );

         always @* begin
            src = 1'b0;
            if (src_sel <= `RCO_SRC_LAST_CHAN) begin
               src = RECOVERED_CLOCK_IN[src_sel];
            end else if (src_sel == `RCO_SRC_EXTERNAL) begin
               src = ext_clk[g];
            end else begin
               src = free_clk;
            end
         end

         // divide by two to the div, any source
         always @(posedge CLK_IN) begin
            if (!rst_n) begin
               src_d_reg <= 1'b0;
               cnt_reg <= 8'h00;
               out_reg <= 1'b0;
            end else begin
               src_d_reg <= src;
               // count rising source edges only
               if (src & ~src_d_reg) begin
                  cnt_reg <= cnt_reg + 8'h01;
               end
               if (div == 3'h0) begin
                  out_reg <= src;
               end else begin
                  out_reg <= cnt_reg[div - 3'h1];
               end
            end
         end

         assign ref_out[g] = out_reg;
         assign ref_oe_n[g] = ~cfg[`RCO_REF_EN];
      end
   endgenerate

   assign REFERENCE_OUT_FIRST_OUT = ref_out[0];
   assign REFERENCE_FIRST_OE_N_OUT = ref_oe_n[0];
   assign REFERENCE_OUT_SECOND_OUT = ref_out[1];
   assign REFERENCE_SECOND_OE_N_OUT = ref_oe_n[1];
   assign CLOCK_LOST_OUT = lost;
endmodule // rco_ref_clock_out

// [tb/rco_checker.sv]
// Purpose: port checker for rco_ref_clock_out
// Assumes: one clock, sync active-low reset
// Notes: straps taken at first edge after reset
`timescale 1ns/10ps
module rco_checker #(
   parameter LOSS_WINDOW = 50
) (
   // clock and reset
   input wire CLK_IN,
   input wire RST_N_IN,
   // register port
   input wire [3:0] ADDR_IN,
   input wire [7:0] WR_DATA_IN,
   input wire WR_EN_IN,
   input wire RD_EN_IN,
   input wire [7:0] RD_DATA_OUT,
   // master clock
   input wire MASTER_CLOCK_IN,
   input wire [3:0] MASTER_FREQ_STRAPS_IN,
   // enables and status
   input wire T1_RATE_CLOCK_OE_N_OUT,
   input wire E1_RATE_CLOCK_OE_N_OUT,
   input wire REFERENCE_FIRST_OE_N_OUT,
   input wire REFERENCE_SECOND_OE_N_OUT,
   input wire CLOCK_LOST_OUT
);
   reg first_reg;
   reg mclk_reg;
   reg [3:0] strap_reg;
   reg [15:0] stuck_reg;
   wire wr0 = WR_EN_IN && ADDR_IN == 4'h0;
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   // cycles since the master clock last moved
   always @(posedge CLK_IN) begin
      first_reg <= !RST_N_IN;
      mclk_reg <= MASTER_CLOCK_IN;
      if (first_reg && RST_N_IN) strap_reg <= MASTER_FREQ_STRAPS_IN;
      if (!RST_N_IN || MASTER_CLOCK_IN != mclk_reg) stuck_reg <= 16'h0000;
      else if (stuck_reg != 16'hFFFF) stuck_reg <= stuck_reg + 16'h0001;
   end
   property p_t1_en;
      wr0 |=> T1_RATE_CLOCK_OE_N_OUT == !$past(WR_DATA_IN[1]);
   endproperty
   a_t1_en: assert property (p_t1_en)
      else $error("t1 enable");
   property p_e1_en;
      wr0 |=> E1_RATE_CLOCK_OE_N_OUT == !$past(WR_DATA_IN[3]);
   endproperty
   a_e1_en: assert property (p_e1_en)
      else $error("e1 enable");
   property p_ref1_en;
      WR_EN_IN && ADDR_IN == 4'h1 |=> REFERENCE_FIRST_OE_N_OUT == !$past(WR_DATA_IN[6]);
   endproperty
   a_ref1_en: assert property (p_ref1_en)
      else $error("ref1 enable");
   property p_ref2_en;
      WR_EN_IN && ADDR_IN == 4'h2 |=> REFERENCE_SECOND_OE_N_OUT == !$past(WR_DATA_IN[6]);
   endproperty
   a_ref2_en: assert property (p_ref2_en)
      else $error("ref2 enable");
   property p_status;
      RD_EN_IN && ADDR_IN == 4'h5 |=> RD_DATA_OUT == {3'h0, $past(CLOCK_LOST_OUT), strap_reg};
   endproperty
   a_status: assert property (p_status)
      else $error("status read");
   property p_cg_rd;
      RD_EN_IN && ADDR_IN == 4'h0 |=> RD_DATA_OUT[7:4] == 4'h0
         && RD_DATA_OUT[1] == !$past(T1_RATE_CLOCK_OE_N_OUT)
         && RD_DATA_OUT[3] == !$past(E1_RATE_CLOCK_OE_N_OUT);
   endproperty
   a_cg_rd: assert property (p_cg_rd)
      else $error("config read");
   property p_lost;
      stuck_reg == 2 * LOSS_WINDOW + 4 |-> CLOCK_LOST_OUT;
   endproperty
   a_lost: assert property (p_lost)
      else $error("loss missed");
   property p_recover;
      $fell(CLOCK_LOST_OUT) |-> ##[0:3] (T1_RATE_CLOCK_OE_N_OUT && E1_RATE_CLOCK_OE_N_OUT
         && REFERENCE_FIRST_OE_N_OUT && REFERENCE_SECOND_OE_N_OUT);
   endproperty
   a_recover: assert property (p_recover)
      else $error("no auto reset");
   c_wr: cover property (wr0 ##1 !T1_RATE_CLOCK_OE_N_OUT);
   c_lost: cover property ($rose(CLOCK_LOST_OUT));
   c_rd: cover property (RD_EN_IN && ADDR_IN == 4'h5);
endmodule // rco_checker
bind rco_ref_clock_out rco_checker #(.LOSS_WINDOW(LOSS_WINDOW)) u_chk (.*);

// [tb/rco_clock_sink.sv]
// Purpose: board clock consumer counting rising edges
// Assumes: pin sampled on the system clock
// Notes: a released pin reads as inverse of its last level
`timescale 1ns/10ps
module rco_clock_sink (
   // clock and reset
   input wire clk_in,
   input wire rst_n_in,
   // pin
   input wire pin_in,
   input wire oe_n_in,
   // count
   output reg [15:0] edges_out
);
   reg lvl_reg;
   wire lvl_next = oe_n_in ? !lvl_reg : pin_in;
   always @(posedge clk_in) begin
      lvl_reg <= lvl_next;
      if (!rst_n_in) edges_out <= 16'h0000;
      else if (!oe_n_in && lvl_next && !lvl_reg) edges_out <= edges_out + 16'h0001;
   end
endmodule // rco_clock_sink

// [tb/rco_ref_clock_out_tb_top.sv]
// Purpose: self-checking bench for rco_ref_clock_out
// Assumes: straps 1001, master clock 240 ns period
// Notes: edge counts allow one edge of slack
`timescale 1ns/10ps
module rco_ref_clock_out_tb_top;
   logic clk = 0, rst_n = 0, we = 0, re = 0, mclk = 0, run = 1, ext = 0, lost_exp = 0;
   logic [3:0] addr = 4'h0, straps = 4'h9;
   logic [7:0] wd = 8'h00;
   logic [16:0] rec = 17'h00000;
   logic [4:0] mph = 5'h00;
   logic [2:0] sph = 3'h0;
   logic [31:0] seed = 32'h5340;
   logic [15:0] base [4];
   int ch = 31, failures = 0, n_tests = 0;
   wire [7:0] rdata;
   wire t1, t1_oe_n, e1, e1_oe_n, r1, r1_oe_n, r2, r2_oe_n, lost;
   wire [15:0] cnt [4];
   always #5 clk = ~clk;
   // selected source toggles every 4 cycles, master every 12
   always @(posedge clk) begin
      sph <= sph + 3'h1;
      rec <= sph[2] ? 17'h00001 << ch : 17'h00000;
      ext <= sph[2] && ch == 17;
      if (run) mph <= (mph == 5'h0B) ? 5'h00 : mph + 5'h01;
      if (run && mph == 5'h0B) mclk <= !mclk;
   end
   rco_ref_clock_out #(.LOSS_WINDOW(50)) DUT (.CLK_IN(clk), .RST_N_IN(rst_n),
      .ADDR_IN(addr), .WR_DATA_IN(wd), .WR_EN_IN(we), .RD_EN_IN(re), .RD_DATA_OUT(rdata),
      .MASTER_CLOCK_IN(mclk), .MASTER_FREQ_STRAPS_IN(straps), .RECOVERED_CLOCK_IN(rec),
      .EXTERNAL_CLOCK_IN_FIRST_IN(ext), .EXTERNAL_CLOCK_IN_SECOND_IN(ext),
      .T1_RATE_CLOCK_OUT(t1), .T1_RATE_CLOCK_OE_N_OUT(t1_oe_n), .E1_RATE_CLOCK_OUT(e1),
      .E1_RATE_CLOCK_OE_N_OUT(e1_oe_n), .REFERENCE_OUT_FIRST_OUT(r1),
      .REFERENCE_FIRST_OE_N_OUT(r1_oe_n), .REFERENCE_OUT_SECOND_OUT(r2),
      .REFERENCE_SECOND_OE_N_OUT(r2_oe_n), .CLOCK_LOST_OUT(lost));
   rco_clock_sink u_s0 (.clk_in(clk), .rst_n_in(rst_n), .pin_in(t1), .oe_n_in(t1_oe_n),
      .edges_out(cnt[0]));
   rco_clock_sink u_s1 (.clk_in(clk), .rst_n_in(rst_n), .pin_in(e1), .oe_n_in(e1_oe_n),
      .edges_out(cnt[1]));
   rco_clock_sink u_s2 (.clk_in(clk), .rst_n_in(rst_n), .pin_in(r1), .oe_n_in(r1_oe_n),
      .edges_out(cnt[2]));
   rco_clock_sink u_s3 (.clk_in(clk), .rst_n_in(rst_n), .pin_in(r2), .oe_n_in(r2_oe_n),
      .edges_out(cnt[3]));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] exp_reg(input logic [3:0] a, input logic [7:0] d);
      case (a)
         4'h0: return d & 8'h0F;
         4'h1, 4'h2: return d & 8'h7F;
         4'h3, 4'h4: return d & 8'h07;
         4'h5: return {3'h0, lost_exp, straps};
         default: return 8'h00;
      endcase
   endfunction
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] ex);
      n_tests++;
      if (got !== ex) begin
         failures++;
         $display("ERROR t=%0t got %h exp %h", $time, got, ex);
      end
   endtask
   task automatic chk_cnt(input logic [15:0] got, input int ex);
      n_tests++;
      if ((^got === 1'bx) || got + 1 < ex || got > ex + 1) begin
         failures++;
         $display("ERROR t=%0t got %h exp %h", $time, got, ex);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wd <= d;
      we <= 1'b1;
      @(posedge clk);
      #1;
      we <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] ex);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      #1;
      re <= 1'b0;
      chk_reg(rdata, ex);
      @(posedge clk);
      #1;
   endtask
   task automatic meas(input int cyc);
      for (int i = 0; i < 4; i++) base[i] = cnt[i];
      repeat (cyc) @(posedge clk);
      #1;
      for (int i = 0; i < 4; i++) base[i] = cnt[i] - base[i];
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #900000;
      failures++;
      end_sim();
   end
   initial begin
      logic [3:0] a;
      logic [7:0] d;
      int n;
      repeat (12) @(posedge clk);
      #1;
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk_reg({4'h0, t1_oe_n, e1_oe_n, r1_oe_n, r2_oe_n}, 8'h0F);
      rd(4'h5, exp_reg(4'h5, 8'h00));
      $display("test reset done");
      for (int i = 0; i < 40; i++) begin
         a = (i == 0) ? 4'hF : (i == 1) ? 4'h5 : 4'(rnd());
         d = 8'(rnd());
         wr(a, d);
         rd(a, exp_reg(a, d));
      end
      $display("test registers done");
      wr(4'h0, 8'h0F);
      meas(512 * 24);
      chk_cnt(base[0], 193);
      chk_cnt(base[1], 256);
      wr(4'h0, 8'h0A);
      meas(1024 * 24);
      chk_cnt(base[0], 2);
      chk_cnt(base[1], 2);
      wr(4'h0, 8'h05);
      chk_reg({6'h00, t1_oe_n, e1_oe_n}, 8'h03);
      $display("test rates done");
      for (int c = 0; c < 18; c++) begin
         n = int'(rnd() % 8);
         wr(4'h1, 8'h40 | 8'(c));
         wr(4'h2, 8'h40 | 8'(c));
         wr(4'h3, 8'(n));
         wr(4'h4, 8'h00);
         ch = c;
         meas(512);
         chk_cnt(base[2], 64 >> n);
         chk_cnt(base[3], 64);
      end
      ch = 31;
      // free-run rate bit: first at T1, second at E1
      wr(4'h1, 8'h40 | 8'(18 + rnd() % 14));
      wr(4'h2, 8'h60 | 8'(18 + rnd() % 14));
      wr(4'h3, 8'h00);
      meas(1000);
      chk_cnt(base[2], 15);
      chk_cnt(base[3], 20);
      wr(4'h1, 8'h1F);
      chk_reg({7'h00, r1_oe_n}, 8'h01);
      $display("test references done");
      wr(4'h0, 8'h0F);
      run <= 1'b0;
      for (n = 0; n < 400 && lost !== 1'b1; n++) @(posedge clk);
      #1;
      lost_exp = 1'b1;
      rd(4'h5, exp_reg(4'h5, 8'h00));
      run <= 1'b1;
      for (n = 0; n < 400 && lost !== 1'b0; n++) @(posedge clk);
      repeat (4) @(posedge clk);
      #1;
      lost_exp = 1'b0;
      chk_reg({7'h00, t1_oe_n}, 8'h01);
      rd(4'h0, 8'h00);
      $display("test loss done");
      end_sim();
   end
endmodule // rco_ref_clock_out_tb_top
